// >>> src/kbm_byte_reg.sv
// one byte holding register with load enable and synchronous clear
// assumes clear is the system reset as seen in clk_i domain
`timescale 1ns/1ps
`default_nettype none
module kbm_byte_reg
  import kbm_pkg::*;
(
  input  wire logic       clk_i,  // system clock
  input  wire logic       clr_i,  // synchronous clear, high
  input  wire logic       ld_i,   // load strobe
  input  wire logic [7:0] d_i,    // load data
  output logic      [7:0] q_o     // held byte
);
  logic [7:0] q_reg;
  logic [7:0] q_next;
  // hold unless loaded
  always_comb begin
    q_next = q_reg;
    if (ld_i) begin
      q_next = d_i;
    end
  end
  // register only
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      q_reg <= KBM_BYTE_RST;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q_o = q_reg;
endmodule
`default_nettype wire

// >>> src/kbm_host_mailbox.sv
// host-facing byte mailbox with controller-side alias port
// assumes host and controller strobes are one-cycle, synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module kbm_host_mailbox
  import kbm_pkg::*;
(
  input  wire logic       clk_i,          // 200 MHz system clock
  input  wire logic       rstn_i,         // system reset, low
  input  wire logic       host_rstn_i,    // host reset, low
  input  wire logic       vcc_rstn_i,     // vcc reset, low
  input  wire logic       activate_i,     // interface activate bit
  input  wire logic       ibf_irq_en_i,   // input full interrupt enable
  input  wire logic       host_wr_i,      // host i/o write strobe
  input  wire logic       host_rd_i,      // host i/o read strobe
  input  wire logic [2:0] host_addr_i,    // host offset
  input  wire logic [7:0] host_wdata_i,   // host write byte
  output logic      [7:0] host_rdata_o,   // host read byte
  input  wire logic       ctl_wr_i,       // controller write strobe
  input  wire logic       ctl_rd_i,       // controller read strobe
  input  wire logic [8:0] ctl_addr_i,     // controller offset
  input  wire logic [7:0] ctl_wdata_i,    // controller write byte
  output logic      [7:0] ctl_rdata_o,    // controller read byte
  output logic            input_full_irq_o,       // level to controller
  output logic            output_empty_irq_o,     // one-cycle pulse
  output logic            primary_output_full_irq_o, // pending ordinary out
  output logic            aux_output_irq_o        // pending aux out
);
  // offset compare for the controller port; host side compares directly
  function automatic logic hit9(input logic [8:0] a, input logic [8:0] b);
    hit9 = (a == b);
  endfunction

  logic h_wd;
  logic h_wc;
  logic h_rd;
  logic c_rd_in;
  logic c_wr_out;
  logic c_wr_aux;
  logic c_wr_stat;

  // decode; host side gated by activate
  always_comb begin
    h_wd      = activate_i && host_wr_i && (host_addr_i == KBM_HOST_DATA_OFS);
    h_wc      = activate_i && host_wr_i && (host_addr_i == KBM_HOST_CMD_OFS);
    h_rd      = activate_i && host_rd_i && (host_addr_i == KBM_HOST_DATA_OFS);
    c_rd_in   = ctl_rd_i && hit9(ctl_addr_i, KBM_CTL_DATA_OFS);
    c_wr_out  = ctl_wr_i && hit9(ctl_addr_i, KBM_CTL_DATA_OFS);
    c_wr_aux  = ctl_wr_i && hit9(ctl_addr_i, KBM_CTL_AUX_OFS);
    c_wr_stat = ctl_wr_i && hit9(ctl_addr_i, KBM_CTL_STAT_OFS);
  end

  logic [7:0] in_byte;
  logic [7:0] out_byte;
  logic       sys_clr;
  assign sys_clr = !rstn_i;

  // inbound byte from either host offset
  kbm_byte_reg u_in (
    .clk_i (clk_i),
    .clr_i (sys_clr),
    .ld_i  (h_wd || h_wc),
    .d_i   (host_wdata_i),
    .q_o   (in_byte)
  );

  // outbound byte held until next controller output write
  kbm_byte_reg u_out (
    .clk_i (clk_i),
    .clr_i (sys_clr),
    .ld_i  (c_wr_out || c_wr_aux),
    .d_i   (ctl_wdata_i),
    .q_o   (out_byte)
  );

  logic [1:0] uhi_reg, uhi_next;
  logic       umid_reg, umid_next;
  logic       ulow_reg, ulow_next;
  logic       aux_reg, aux_next;
  logic       cd_reg, cd_next;
  logic       ibf_reg, ibf_next;
  logic       obf_reg, obf_next;
  logic       pri_irq_reg, pri_irq_next;
  logic       aux_irq_reg, aux_irq_next;
  logic       obe_reg, obe_next;

  // status flag next values; sets win over clears
  always_comb begin
    uhi_next     = uhi_reg;
    umid_next    = umid_reg;
    ulow_next    = ulow_reg;
    aux_next     = aux_reg;
    cd_next      = cd_reg;
    ibf_next     = ibf_reg;
    obf_next     = obf_reg;
    pri_irq_next = pri_irq_reg;
    aux_irq_next = aux_irq_reg;
    obe_next     = 1'b0;
    if (c_wr_stat) begin // user fields only from controller alias
      uhi_next  = ctl_wdata_i[KBM_BIT_UHI +: 2];
      umid_next = ctl_wdata_i[KBM_BIT_UMID];
      ulow_next = ctl_wdata_i[KBM_BIT_ULOW];
    end
    if (h_wd) begin
      cd_next = 1'b0;
    end
    if (h_wc) begin
      cd_next = 1'b1;
    end
    if (c_rd_in) begin
      ibf_next = 1'b0;
    end
    if (h_wd || h_wc) begin
      ibf_next = 1'b1;
    end
    if (h_rd) begin
      obf_next     = 1'b0;
      pri_irq_next = 1'b0;
      aux_irq_next = 1'b0;
      obe_next     = 1'b1;
    end
    if (c_wr_out) begin
      aux_next     = 1'b0;
      obf_next     = 1'b1;
      pri_irq_next = 1'b1;
    end
    if (c_wr_aux) begin
      aux_next     = 1'b1;
      obf_next     = 1'b1;
      aux_irq_next = 1'b1;
    end
  end

  // flags on system reset; vcc reset spares ibf/obf
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      uhi_reg     <= KBM_UHI_RST;
      umid_reg    <= KBM_FLAG_RST;
      aux_reg     <= KBM_FLAG_RST;
      cd_reg      <= KBM_FLAG_RST;
      ibf_reg     <= KBM_FLAG_RST;
      obf_reg     <= KBM_FLAG_RST;
      pri_irq_reg <= KBM_FLAG_RST;
      aux_irq_reg <= KBM_FLAG_RST;
      obe_reg     <= KBM_FLAG_RST;
    end else begin
      uhi_reg     <= uhi_next;
      umid_reg    <= umid_next;
      aux_reg     <= aux_next;
      cd_reg      <= cd_next;
      ibf_reg     <= ibf_next;
      obf_reg     <= obf_next;
      pri_irq_reg <= !vcc_rstn_i ? KBM_FLAG_RST : pri_irq_next;
      aux_irq_reg <= !vcc_rstn_i ? KBM_FLAG_RST : aux_irq_next;
      obe_reg     <= obe_next;
    end
  end

  // bit 2 has its own host reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !host_rstn_i) begin
      ulow_reg <= KBM_FLAG_RST;
    end else begin
      ulow_reg <= ulow_next;
    end
  end

  logic [7:0] status;
  // assembled status byte, same view for host and controller
  always_comb begin
    status                = 8'h00;
    status[KBM_BIT_UHI+:2] = uhi_reg;
    status[KBM_BIT_AUX]   = aux_reg;
    status[KBM_BIT_UMID]  = umid_reg;
    status[KBM_BIT_CD]    = cd_reg;
    status[KBM_BIT_ULOW]  = ulow_reg;
    status[KBM_BIT_IBF]   = ibf_reg;
    status[KBM_BIT_OBF]   = obf_reg;
  end

  logic [7:0] hrd_reg, hrd_next;
  logic [7:0] crd_reg, crd_next;
  // read data, registered one cycle after strobe
  always_comb begin
    hrd_next = hrd_reg;
    crd_next = crd_reg;
    if (activate_i && host_rd_i) begin
      hrd_next = 8'h00;
      if (host_addr_i == KBM_HOST_DATA_OFS) begin
        hrd_next = out_byte;
      end else if (host_addr_i == KBM_HOST_CMD_OFS) begin
        hrd_next = status;
      end
    end
    if (ctl_rd_i) begin
      crd_next = 8'h00;
      if (hit9(ctl_addr_i, KBM_CTL_DATA_OFS)) begin
        crd_next = in_byte;
      end else if (hit9(ctl_addr_i, KBM_CTL_STAT_OFS)) begin
        crd_next = status;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hrd_reg <= KBM_BYTE_RST;
      crd_reg <= KBM_BYTE_RST;
    end else begin
      hrd_reg <= hrd_next;
      crd_reg <= crd_next;
    end
  end

  assign host_rdata_o              = hrd_reg;
  assign ctl_rdata_o               = crd_reg;
  assign input_full_irq_o          = ibf_reg && ibf_irq_en_i;
  assign output_empty_irq_o        = obe_reg;
  assign primary_output_full_irq_o = pri_irq_reg;
  assign aux_output_irq_o          = aux_irq_reg;
endmodule
`default_nettype wire

// >>> src/kbm_pkg.sv
// package for the host-facing keyboard-controller byte mailbox
// assumes one 200 MHz clock and single-cycle host and controller strobes
// What this block does
// - host data-offset write latches byte, clears command flag, sets input full
// - host command-offset write latches byte, sets command flag and input full
// - host data read returns posted byte, clears output full and output interrupts
// - host status read returns status byte with no side effects
// - host registers are eight bits; inbound write-only, outbound read-only
// - user fields at bits 7:6, 4, 2 are written only by the controller; bit 2 also clears on host reset
// - controller aux output write sets aux output full, bit 5
// - controller ordinary output write clears aux output full
// - bit 3 shows command or data from the last host write
// - bit 1 input full sets on any host data or command write
// - input full drives the controller interrupt when enabled
// - controller read of inbound alias clears input full and its interrupt
// - bit 0 output full sets on any controller output write
// - host outbound read clears output full and pulses output-empty interrupt
// - input and output full survive the vcc reset; cleared by system reset
// - bit 2 resets on host reset; other state resets on system reset
// - the host side works only while the activate bit is one
// - controller read at 100h returns the byte the host last wrote
// - controller writes 100h for ordinary, 10ch for aux output data
package kbm_pkg;
  localparam logic [2:0]  KBM_HOST_DATA_OFS = 3'h0;   // host data / outbound
  localparam logic [2:0]  KBM_HOST_CMD_OFS  = 3'h4;   // host command / status
  localparam logic [8:0]  KBM_CTL_DATA_OFS  = 9'h100; // inbound alias / ordinary out
  localparam logic [8:0]  KBM_CTL_STAT_OFS  = 9'h104; // controller status alias
  localparam logic [8:0]  KBM_CTL_AUX_OFS   = 9'h10c; // aux output data
  localparam int          KBM_BIT_UHI       = 6;      // user_field_high 7:6
  localparam int          KBM_BIT_AUX       = 5;
  localparam int          KBM_BIT_UMID      = 4;
  localparam int          KBM_BIT_CD        = 3;
  localparam int          KBM_BIT_ULOW      = 2;
  localparam int          KBM_BIT_IBF       = 1;
  localparam int          KBM_BIT_OBF       = 0;
  localparam logic [7:0]  KBM_BYTE_RST      = 8'h00;
  localparam logic [1:0]  KBM_UHI_RST       = 2'h0;
  localparam logic        KBM_FLAG_RST      = 1'b0;
endpackage

// >>> verification/kbm_host_mailbox_sva.sv
// checker for the host mailbox, bound to its top module
// assumes one clock; system reset disables every property
`timescale 1ns/1ps
`default_nettype none
module kbm_host_mailbox_sva
  import kbm_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       vcc_rstn_i,
  input wire logic       activate_i,
  input wire logic       ibf_irq_en_i,
  input wire logic       host_wr_i,
  input wire logic       host_rd_i,
  input wire logic [2:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic       ctl_wr_i,
  input wire logic       ctl_rd_i,
  input wire logic [8:0] ctl_addr_i,
  input wire logic [7:0] ctl_rdata_o,
  input wire logic       input_full_irq_o,
  input wire logic       output_empty_irq_o,
  input wire logic       primary_output_full_irq_o,
  input wire logic       aux_output_irq_o
);
  logic hw;
  logic hr0;
  logic cr;
  // accepted host and controller strobes
  assign hw  = host_wr_i & activate_i & ((host_addr_i == 3'h0) | (host_addr_i == 3'h4));
  assign hr0 = host_rd_i & activate_i & (host_addr_i == 3'h0);
  assign cr  = ctl_rd_i & (ctl_addr_i == 9'h100);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ibf_set_a: assert property (hw |=> input_full_irq_o == ibf_irq_en_i)
    else $error("input full interrupt wrong after host write");
  ibf_clr_a: assert property (cr && !hw |=> !input_full_irq_o)
    else $error("input full interrupt kept after alias read");
  alias_rd_a: assert property (hw ##1 !host_wr_i ##1 (cr && !host_wr_i) |=> ctl_rdata_o == $past(host_wdata_i, 3))
    else $error("alias read lost the host byte");
  obe_set_a: assert property (hr0 |=> output_empty_irq_o)
    else $error("no output empty pulse after host data read");
  aux_set_a: assert property (ctl_wr_i && ctl_addr_i == 9'h10c && !hr0 && vcc_rstn_i |=> aux_output_irq_o)
    else $error("aux output pending not raised");
  rd_clr_a: assert property (hr0 && !ctl_wr_i |=> !primary_output_full_irq_o && !aux_output_irq_o)
    else $error("output pending kept after host data read");
  hold_a: assert property (!host_rd_i |=> $stable(host_rdata_o))
    else $error("host read byte changed without a read");
  inactive_a: assert property (!activate_i && host_rd_i |=> $stable(host_rdata_o) && !output_empty_irq_o)
    else $error("inactive interface answered a host read");
  cover property (hw ##2 cr);
  cover property (ctl_wr_i ##2 hr0);
  cover property (!activate_i && host_wr_i);
endmodule

bind kbm_host_mailbox kbm_host_mailbox_sva kbm_host_mailbox_sva_inst (
  .clk_i, .rstn_i, .vcc_rstn_i, .activate_i, .ibf_irq_en_i, .host_wr_i, .host_rd_i, .host_addr_i, .host_wdata_i,
  .host_rdata_o, .ctl_wr_i, .ctl_rd_i, .ctl_addr_i, .ctl_rdata_o, .input_full_irq_o,
  .output_empty_irq_o, .primary_output_full_irq_o, .aux_output_irq_o);
`default_nettype wire

// >>> verification/kbm_host_model.sv
// host processor model issuing single-byte i/o cycles
// assumes the bench calls xfer from one procedural thread
`timescale 1ns/1ps
`default_nettype none
module kbm_host_model (
  input  wire logic       clk_i,   // system clock
  input  wire logic [7:0] rdata_i, // read byte
  output var  logic       wr_o,    // write strobe
  output var  logic       rd_o,    // read strobe
  output var  logic [2:0] addr_o,  // offset
  output var  logic [7:0] wdata_o  // write byte
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 3'h0;
    wdata_o = 8'h00;
  end
  // one byte-wide strobe cycle; the answer is taken one edge later
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a; // released lines stop showing the old value
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the host mailbox
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       host_rstn_i = 1'b1;
  logic       vcc_rstn_i = 1'b1;
  logic       activate_i = 1'b1;
  logic       ibf_irq_en_i = 1'b1;
  logic       host_wr_i, host_rd_i, input_full_irq_o, output_empty_irq_o;
  logic       primary_output_full_irq_o, aux_output_irq_o;
  logic       ctl_wr_i = 1'b0;
  logic       ctl_rd_i = 1'b0;
  logic [2:0] host_addr_i;
  logic [7:0] host_wdata_i, host_rdata_o, ctl_rdata_o, q;
  logic [7:0] ctl_wdata_i = 8'h00;
  logic [8:0] ctl_addr_i = 9'h000;
  int         fails = 0;
  int         checked = 0;
  always #2.5 clk_i = ~clk_i;
  kbm_host_mailbox kbm_host_mailbox_inst (.clk_i, .rstn_i, .host_rstn_i, .vcc_rstn_i, .activate_i,
    .ibf_irq_en_i, .host_wr_i, .host_rd_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .ctl_wr_i,
    .ctl_rd_i, .ctl_addr_i, .ctl_wdata_i, .ctl_rdata_o, .input_full_irq_o, .output_empty_irq_o,
    .primary_output_full_irq_o, .aux_output_irq_o);
  kbm_host_model kbm_host_model_inst (.clk_i, .rdata_i(host_rdata_o), .wr_o(host_wr_i),
    .rd_o(host_rd_i), .addr_o(host_addr_i), .wdata_o(host_wdata_i));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host and controller accesses
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    kbm_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    kbm_host_model_inst.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic ctl(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    ctl_wr_i = w;
    ctl_rd_i = !w;
    ctl_addr_i = a;
    ctl_wdata_i = d;
    @(posedge clk_i);
    #1;
    ctl_wr_i = 1'b0;
    ctl_rd_i = 1'b0;
  endtask
  // one-cycle pulse on a reset line
  task automatic pulse(ref logic r);
    r = 1'b0;
    @(posedge clk_i);
    #1;
    r = 1'b1;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #20000;
    fails++;
    close_out;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    rdc(3'h4, 8'h00);
    rdc(3'h0, 8'h00);
    wr(3'h0, 8'h5a);
    rdc(3'h4, 8'h02);
    chk({7'h00, input_full_irq_o}, 8'h01);
    ibf_irq_en_i = 1'b0;
    wr(3'h4, 8'ha5);
    chk({7'h00, input_full_irq_o}, 8'h00);
    ibf_irq_en_i = 1'b1;
    ctl(1'b0, 9'h100, 8'h00);
    chk(ctl_rdata_o, 8'ha5);
    rdc(3'h4, 8'h08);
    ctl(1'b1, 9'h104, 8'hff);
    rdc(3'h4, 8'hdc);
    pulse(host_rstn_i);
    rdc(3'h4, 8'hd8);
    ctl(1'b1, 9'h104, 8'h00);
    ctl(1'b1, 9'h10c, 8'h33);
    rdc(3'h4, 8'h29);
    ctl(1'b1, 9'h100, 8'h44);
    rdc(3'h4, 8'h09);
    chk({6'h00, primary_output_full_irq_o, aux_output_irq_o}, 8'h03);
    rdc(3'h0, 8'h44);
    chk({7'h00, output_empty_irq_o}, 8'h01);
    chk({6'h00, primary_output_full_irq_o, aux_output_irq_o}, 8'h00);
    rdc(3'h4, 8'h08);
    rdc(3'h0, 8'h44);
    ctl(1'b1, 9'h10c, 8'h66);
    rdc(3'h0, 8'h66);
    wr(3'h0, 8'h11);
    ctl(1'b1, 9'h100, 8'h22);
    pulse(vcc_rstn_i);
    rdc(3'h4, 8'h03);
    activate_i = 1'b0;
    wr(3'h4, 8'h77);
    rdc(3'h0, 8'h03);
    activate_i = 1'b1;
    rdc(3'h4, 8'h03);
    ctl(1'b0, 9'h100, 8'h00);
    chk(ctl_rdata_o, 8'h11);
    pulse(rstn_i);
    rdc(3'h4, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
